// ### rtl/app_pkg.sv
// Package with constants and carrier types for the parallel host port.
package app_pkg;

  // ==========================================================================
  // Widths and layout
  localparam int DATA_W = 12;
  localparam int CHAN_W = 3;
  localparam int BYTE_W = 8;
  localparam int HI_MSB_LO = 0;
  localparam int HI_ID_LO = 5;
  localparam int CONV_FALLS = 14;
  localparam int TRACK_RISES = 13;

  // ==========================================================================
  // Control register layout and reset value
  localparam int PM_LO_BIT = 4;
  localparam int PM_HI_BIT = 5;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // ==========================================================================
  // Power modes, upper bit first
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_AUTO_SHUTDOWN = 2'b01,
    PM_AUTO_STANDBY = 2'b10,
    PM_FULL_SHUTDOWN = 2'b11
  } app_pmode_t;

  // ==========================================================================
  // Conversion sequencing states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_CONV = 2'b01,
    CS_DONE = 2'b10
  } app_conv_t;

  // ==========================================================================
  // Host bus pins after synchronisation
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic word_mode;
    logic [DATA_W-1:0] din;
  } app_bus_t;

  // Result handed from the converter core
  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic [CHAN_W-1:0] chan;
  } app_result_t;

  // Power state shown to the analog side
  typedef struct packed {
    logic core_on;
    logic ref_on;
    logic track;
  } app_power_t;

endpackage

// ### rtl/app_port.sv
// Parallel host port with control register and power-mode sequencing.
`timescale 1ns/1ps
module app_port #(
  parameter int TEN_BIT = 0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host bus pins, asynchronous
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic word_mode,
  input wire logic conversion_start_n,
  input wire logic conversion_clock,
  input wire logic [app_pkg::DATA_W-1:0] data_in,
  // Data bus drive; bit 8 is shared_data8_half_select_pin
  output logic [app_pkg::DATA_W-1:0] data_out,
  output logic [app_pkg::DATA_W-1:0] data_oe,
  // Shadow register select and output
  input wire logic shadow_select,
  output logic [app_pkg::BYTE_W-1:0] shadow_q_out,
  // Converter core
  input wire logic [app_pkg::DATA_W-1:0] result_code,
  input wire logic [app_pkg::CHAN_W-1:0] result_chan,
  // Status and control
  output logic busy,
  output logic [app_pkg::DATA_W-1:0] control_word,
  output app_pkg::app_power_t power_state
);

  // ==========================================================================
  // Synchronisers
  localparam int SW = 6 + app_pkg::DATA_W;
  logic [SW-1:0] sync_v;
  app_pkg::app_bus_t bus;
  logic cst_s;
  logic cclk_s;

  app_sync #(.W(SW)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({cs_n, rd_n, wr_n, word_mode, data_in, conversion_start_n,
      conversion_clock}),
    .sync_out(sync_v)
  );

  always_comb
  begin
    bus = app_pkg::app_bus_t'(sync_v[SW-1:2]);
    cst_s = sync_v[1];
    cclk_s = sync_v[0];
  end

  // ==========================================================================
  // Edge detection on synchronised levels
  logic wr_act_q;
  logic cst_q;
  logic cclk_q;
  logic wr_act;
  logic wr_rise;
  logic cst_fall;
  logic cst_rise;
  logic cclk_fall;
  logic cclk_rise;
  logic half_sel;

  always_comb
  begin
    wr_act = !bus.cs_n && !bus.wr_n;
    wr_rise = wr_act_q && !wr_act;
    cst_fall = cst_q && !cst_s;
    cst_rise = !cst_q && cst_s;
    cclk_fall = cclk_q && !cclk_s;
    cclk_rise = !cclk_q && cclk_s;
    half_sel = bus.din[8];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_act_q <= 1'b0;
      cst_q <= 1'b1;
      cclk_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= wr_act;
      cst_q <= cst_s;
      cclk_q <= cclk_s;
    end
  end

  // ==========================================================================
  // Write path: control, shadow and byte assembly
  // The write data is sampled one cycle before the strobe edge is seen, so
  // the host's hold time after the rising strobe is not needed here.
  logic [app_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [app_pkg::DATA_W-1:0] ctrl_q, ctrl_d;
  logic [app_pkg::BYTE_W-1:0] lo_q, lo_d;
  logic lo_valid_q, lo_valid_d;
  logic [app_pkg::BYTE_W-1:0] shadow_q, shadow_d;
  logic ctrl_wr;

  always_comb
  begin
    wdata_d = wr_act ? bus.din : wdata_q;
    ctrl_d = ctrl_q;
    lo_d = lo_q;
    lo_valid_d = lo_valid_q;
    shadow_d = shadow_q;
    ctrl_wr = 1'b0;
    if (wr_rise)
    begin
      if (shadow_select)
        shadow_d = wdata_q[app_pkg::BYTE_W-1:0];
      else if (bus.word_mode)
      begin
        ctrl_d = wdata_q;
        ctrl_wr = 1'b1;
      end
      else if (!wdata_q[8])
      begin
        lo_d = wdata_q[app_pkg::BYTE_W-1:0];
        lo_valid_d = 1'b1;
      end
      else if (lo_valid_q)
      begin
        ctrl_d = {wdata_q[3:0], lo_q};
        ctrl_wr = 1'b1;
        lo_valid_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wdata_q <= '0;
      ctrl_q <= app_pkg::CTRL_RESET;
      lo_q <= '0;
      lo_valid_q <= 1'b0;
      shadow_q <= '0;
    end
    else
    begin
      wdata_q <= wdata_d;
      ctrl_q <= ctrl_d;
      lo_q <= lo_d;
      lo_valid_q <= lo_valid_d;
      shadow_q <= shadow_d;
    end
  end

  // ==========================================================================
  // Conversion and power sequencing
  app_pkg::app_conv_t cst_state_q, cst_state_d;
  logic [4:0] falls_q, falls_d;
  logic [4:0] rises_q, rises_d;
  logic track_q, track_d;
  logic core_on_q, core_on_d;
  logic ref_on_q, ref_on_d;
  logic [app_pkg::DATA_W-1:0] res_q, res_d;
  logic [app_pkg::CHAN_W-1:0] chan_q, chan_d;
  app_pkg::app_pmode_t pm;

  always_comb
  begin
    pm = app_pkg::app_pmode_t'({ctrl_q[app_pkg::PM_HI_BIT],
      ctrl_q[app_pkg::PM_LO_BIT]});
    cst_state_d = cst_state_q;
    falls_d = falls_q;
    rises_d = rises_q;
    track_d = track_q;
    core_on_d = core_on_q;
    ref_on_d = ref_on_q;
    res_d = res_q;
    chan_d = chan_q;
    if (ctrl_wr && ctrl_d[app_pkg::PM_HI_BIT] && ctrl_d[app_pkg::PM_LO_BIT])
    begin
      core_on_d = 1'b0;
      ref_on_d = 1'b0;
      track_d = 1'b0;
      cst_state_d = app_pkg::CS_IDLE;
    end
    else if (ctrl_wr && pm != app_pkg::PM_NORMAL
      && ctrl_d[app_pkg::PM_HI_BIT:app_pkg::PM_LO_BIT] == 2'b00)
    begin
      core_on_d = 1'b1;
      ref_on_d = 1'b1;
      track_d = 1'b1;
    end
    else
    begin
      case (cst_state_q)
        app_pkg::CS_IDLE:
        begin
          if (cst_rise && pm != app_pkg::PM_FULL_SHUTDOWN)
          begin
            track_d = 1'b1;
            core_on_d = 1'b1;
            ref_on_d = 1'b1;
          end
          else if (cst_fall && pm != app_pkg::PM_FULL_SHUTDOWN)
          begin
            cst_state_d = app_pkg::CS_CONV;
            track_d = 1'b0;
            falls_d = '0;
            rises_d = '0;
          end
        end
        app_pkg::CS_CONV:
        begin
          if (cclk_fall && falls_q < 5'(app_pkg::CONV_FALLS))
            falls_d = falls_q + 5'd1;
          if (cclk_rise && rises_q < 5'(app_pkg::TRACK_RISES))
            rises_d = rises_q + 5'd1;
          if (cst_rise && falls_q < 5'(app_pkg::CONV_FALLS))
          begin
            cst_state_d = app_pkg::CS_IDLE;
            track_d = 1'b1;
          end
          else if (rises_q == 5'(app_pkg::TRACK_RISES)
            && falls_q == 5'(app_pkg::CONV_FALLS))
          begin
            res_d = result_code;
            chan_d = result_chan;
            cst_state_d = app_pkg::CS_DONE;
          end
        end
        app_pkg::CS_DONE:
        begin
          cst_state_d = app_pkg::CS_IDLE;
          track_d = 1'b1;
          if (pm == app_pkg::PM_AUTO_SHUTDOWN)
          begin
            core_on_d = 1'b0;
            ref_on_d = 1'b0;
            track_d = 1'b0;
          end
          else if (pm == app_pkg::PM_AUTO_STANDBY)
          begin
            core_on_d = 1'b0;
            track_d = 1'b0;
          end
        end
        default:
          cst_state_d = app_pkg::CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cst_state_q <= app_pkg::CS_IDLE;
      falls_q <= '0;
      rises_q <= '0;
      track_q <= 1'b0;
      core_on_q <= 1'b1;
      ref_on_q <= 1'b1;
      res_q <= '0;
      chan_q <= '0;
    end
    else
    begin
      cst_state_q <= cst_state_d;
      falls_q <= falls_d;
      rises_q <= rises_d;
      track_q <= track_d;
      core_on_q <= core_on_d;
      ref_on_q <= ref_on_d;
      res_q <= res_d;
      chan_q <= chan_d;
    end
  end

  // ==========================================================================
  // Read path
  // Result registers load a cycle before busy drops, so a bus held in read
  // already shows the new word when busy falls.
  logic [app_pkg::DATA_W-1:0] rd_word_d, rd_word_q;
  logic [app_pkg::DATA_W-1:0] rd_oe_d, rd_oe_q;
  logic [app_pkg::BYTE_W-1:0] lo_byte;

  always_comb
  begin
    lo_byte = (TEN_BIT != 0) ? {res_q[5:0], 2'b00} : res_q[7:0];
    rd_word_d = '0;
    rd_oe_d = '0;
    if (!bus.cs_n && !bus.rd_n)
    begin
      if (bus.word_mode)
      begin
        rd_word_d = res_q;
        rd_oe_d = '1;
      end
      else
      begin
        rd_oe_d = 12'h0ff;
        if (half_sel)
          rd_word_d = {4'h0, chan_q, 1'b0, res_q[11:8]};
        else
          rd_word_d = {4'h0, lo_byte};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_word_q <= '0;
      rd_oe_q <= '0;
    end
    else
    begin
      rd_word_q <= rd_word_d;
      rd_oe_q <= rd_oe_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign data_out = rd_word_q;
  assign data_oe = rd_oe_q;
  assign busy = (cst_state_q != app_pkg::CS_IDLE);
  assign control_word = ctrl_q;
  assign shadow_q_out = shadow_q;
  assign power_state = '{core_on: core_on_q, ref_on: ref_on_q,
    track: track_q};

endmodule

// ### rtl/app_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module app_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Idle pins are high, so reset to ones to avoid a false strobe.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### test/app_host.sv
// Host processor model driving the parallel bus pins.
`timescale 1ns/1ps
module app_host (
  // Clock
  input wire logic core_clk,
  // Device drive
  input wire logic [app_pkg::DATA_W-1:0] data_out,
  input wire logic [app_pkg::DATA_W-1:0] data_oe,
  // Host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [app_pkg::DATA_W-1:0] data_in
);
  logic [11:0] drv_q, en_q, last_q;
  initial
  begin
    {cs_n, rd_n, wr_n} = 3'h7;
    {drv_q, en_q, last_q} = '0;
  end
  // Lines nobody drives flip every cycle so a stale value never matches.
  assign data_in = (data_oe & data_out) | (~data_oe & en_q & drv_q)
    | (~data_oe & ~en_q & ~last_q);
  always @(posedge core_clk) last_q <= data_in;
  task automatic wr_cycle(input logic [11:0] d);
    @(posedge core_clk);
    drv_q <= d;
    en_q <= '1;
    {cs_n, wr_n} <= 2'b00;
    repeat (4) @(posedge core_clk);
    {cs_n, wr_n} <= 2'b11;
    repeat (4) @(posedge core_clk);
    en_q <= '0;
  endtask
  task automatic rd_cycle(input logic hb, output logic [11:0] q);
    @(posedge core_clk);
    drv_q <= {3'h0, hb, 8'h00};
    en_q <= 12'h100;
    {cs_n, rd_n} <= 2'b00;
    repeat (5) @(posedge core_clk);
    q = data_in;
    {cs_n, rd_n} <= 2'b11;
    en_q <= '0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ### test/app_port_sva.sv
// Assertion checker for the parallel host port.
`timescale 1ns/1ps
module app_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic word_mode,
  input wire logic conversion_start_n,
  // Device outputs
  input wire logic [app_pkg::DATA_W-1:0] data_oe,
  input wire logic busy,
  input wire logic [app_pkg::DATA_W-1:0] control_word,
  input wire app_pkg::app_power_t power_state
);
  // ==========================================================================
  // Bus and power checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic rd_on;
  logic [1:0] pm;
  assign rd_on = !cs_n && !rd_n;
  assign pm = control_word[5:4];
  a_oe_cause: assert property (data_oe != '0 |-> $past(rd_on, 3))
    else $error("bus driven without a read");
  a_word_oe: assert property ((rd_on && word_mode) [*4] |->
    data_oe == 12'hfff) else $error("word read not on all lines");
  a_byte_oe: assert property ((rd_on && !word_mode) [*4] |->
    data_oe == 12'h0ff) else $error("byte read not on lines 0 to 7");
  a_bus_release: assert property (rd_n [*4] |-> data_oe == '0)
    else $error("bus not released");
  a_busy_start: assert property ($fell(conversion_start_n) && !busy
    && pm != 2'b11 |-> ##[2:4] busy) else $error("busy did not rise");
  a_busy_end: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("busy never fell");
  a_ctrl_cause: assert property ($changed(control_word) |->
    $past(!wr_n, 4) || $past(!wr_n, 5) || $past(!wr_n, 6))
    else $error("control changed without a write");
  a_full_off: assert property ((pm == 2'b11) [*3] |->
    power_state == 3'b000) else $error("powered in full shutdown");
  a_normal_on: assert property ((pm == 2'b00) [*3] |->
    power_state.core_on && power_state.ref_on)
    else $error("normal mode not powered");
  a_standby_ref: assert property ((pm == 2'b10) [*3] |->
    power_state.ref_on) else $error("reference off in standby");
  a_auto_off: assert property ($fell(busy) && pm == 2'b01 |->
    ##[0:2] power_state == 3'b000) else $error("no auto shutdown");
  c_conv: cover property ($fell(busy));
  c_wake: cover property (pm == 2'b11 ##1 pm == 2'b00);
  c_standby: cover property (power_state.ref_on && !power_state.core_on);
endmodule

bind app_port app_chk u_chk (.core_clk, .rst, .cs_n, .rd_n, .wr_n,
  .word_mode, .conversion_start_n, .data_oe, .busy, .control_word,
  .power_state);

// ### test/testbench.sv
// Self-checking bench for the parallel host port.
`timescale 1ns/1ps
module testbench;
  logic core_clk, rst, word_mode, start_n, conv_clk, shadow_sel;
  logic cs_n, rd_n, wr_n, busy;
  logic [11:0] res_code, data_in, data_out, data_oe, control_word, q;
  logic [2:0] res_chan;
  logic [1:0] div;
  logic [7:0] shadow;
  logic [11:0] pm_tbl [2] = '{12'h010, 12'h020};
  logic [11:0] pd_tbl [2] = '{12'h000, 12'h002};
  app_pkg::app_power_t pwr;
  int n_errors, comparisons;
  app_port #(.TEN_BIT(0)) uut (.core_clk, .rst, .cs_n, .rd_n, .wr_n,
    .word_mode, .conversion_start_n(start_n), .conversion_clock(conv_clk),
    .data_in, .data_out, .data_oe, .shadow_select(shadow_sel),
    .shadow_q_out(shadow), .result_code(res_code), .result_chan(res_chan),
    .busy, .control_word, .power_state(pwr));
  app_host host (.core_clk, .data_out, .data_oe, .cs_n, .rd_n, .wr_n,
    .data_in);
  // ==========================================================================
  // Clocks and helpers
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Conversion clock at one eighth of the core rate, slow enough to sample.
  always @(posedge core_clk)
  begin
    div <= div + 2'h1;
    if (div == 2'h3) conv_clk <= ~conv_clk;
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 400 && busy !== v; i++) @(posedge core_clk);
    check(12'(busy), 12'(v));
  endtask
  task automatic convert;
    start_n <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    tick(3);
  endtask
  initial
  begin
    #300000;
    n_errors++;
    report_and_stop;
  end
  // ==========================================================================
  // Tests
  initial
  begin
    {rst, word_mode, div, conv_clk} = 5'h1b;
    {start_n, shadow_sel, n_errors, comparisons} = '0;
    res_code = 12'habc;
    res_chan = 3'h5;
    tick(5);
    rst <= 1'b0;
    tick(4);
    check(control_word, 12'h000);
    check(12'(pwr), 12'h006);
    start_n <= 1'b1;
    tick(6);
    check(12'(pwr), 12'h007);
    convert;
    start_n <= 1'b1;
    host.rd_cycle(1'b0, q);
    check(q, 12'habc);
    $display("word read done");
    start_n <= 1'b0;
    wait_busy(1'b1);
    tick(10);
    start_n <= 1'b1;
    tick(8);
    check(12'(busy), 12'h000);
    check(12'(pwr), 12'h007);
    $display("abort done");
    word_mode <= 1'b0;
    res_code <= res_code ^ 12'h979;
    res_chan <= res_chan + 3'h1;
    tick(4);
    convert;
    start_n <= 1'b1;
    host.rd_cycle(1'b0, q);
    check(12'(q[7:0]), 12'h0c5);
    host.rd_cycle(1'b1, q);
    check(12'(q[7:0]), 12'h0c3);
    $display("byte read done");
    host.wr_cycle(12'h08a);
    check(control_word, 12'h000);
    host.wr_cycle(12'h101);
    check(control_word, 12'h18a);
    host.wr_cycle(12'h102);
    check(control_word, 12'h18a);
    shadow_sel <= 1'b1;
    host.wr_cycle(12'h0a5);
    shadow_sel <= 1'b0;
    check(12'(shadow), 12'h0a5);
    check(control_word, 12'h18a);
    $display("byte write done");
    word_mode <= 1'b1;
    tick(4);
    foreach (pm_tbl[k])
    begin
      host.wr_cycle(pm_tbl[k]);
      check(control_word, pm_tbl[k]);
      convert;
      check(12'(pwr), pd_tbl[k]);
      start_n <= 1'b1;
      tick(6);
      check(12'(pwr), 12'h007);
      tick(20);
    end
    host.wr_cycle(12'h030);
    check(12'(pwr), 12'h000);
    start_n <= 1'b0;
    tick(10);
    check(12'(busy), 12'h000);
    start_n <= 1'b1;
    host.wr_cycle(12'h000);
    check(12'(pwr), 12'h007);
    tick(20);
    $display("power modes done");
    report_and_stop;
  end
endmodule
